// [rtl/cbf_core.v]
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "cbf_map.vh"
module cbf_core #(
  parameter NBUF = 4
) (
  input  wire        ref_clk,     // System clock
  input  wire        sys_rst,     // Sync reset, high
  input  wire        wb_cyc_i,    // Wishbone cycle
  input  wire        wb_stb_i,    // Wishbone strobe
  input  wire        wb_we_i,     // Write enable
  input  wire [7:0]  wb_adr_i,    // Byte address
  input  wire [3:0]  wb_sel_i,    // Byte lanes
  input  wire [31:0] wb_dat_i,    // Write data
  output reg  [31:0] wb_dat_o,    // Read data
  output reg         wb_ack_o,    // Acknowledge
  input  wire        rxIdValid,   // Received ID ready, one cycle
  input  wire [28:0] rxId,        // Received identifier
  input  wire        rxRemote,    // Received frame is remote request
  input  wire        intermission,// Intermission end pulse
  input  wire        busFrameStart,// Foreign frame start pulse
  input  wire        txWon,       // Candidate sent successfully, pulse
  output reg         txReq,       // Candidate present
  output reg  [1:0]  txIndex,     // Candidate buffer index
  output reg         irq          // Interrupt level
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [31:0] cfgReg;
  reg [31:0] gMaskReg;
  reg [31:0] m14Reg;
  reg [31:0] m15Reg;
  reg [3:0]  statReg;
  reg [3:0]  iMaskReg;
  reg [31:0] rxResReg;
  reg [31:0] fifoReg;
  reg [3:0]  codeReg  [0:NBUF-1];
  reg [31:0] idReg    [0:NBUF-1];
  reg [31:0] imrReg   [0:NBUF-1];
  reg        abortPend[0:NBUF-1];
  reg [31:0] rxIdLatch;
  reg        scanPend;
  reg        candValid;
  reg [1:0]  candIdx;
  reg        stallReg;
  integer    i;
  // Separate loop indices so the two combinational scans and the reset loop
  // never share one variable across processes.
  integer    j;
  integer    k;
  wire rx_fifo_enable  = cfgReg[`CBF_CFG_FEN];
  wire bcc  = cfgReg[`CBF_CFG_BCC];
  wire [1:0] lastIdx = cfgReg[`CBF_CFG_LAST_HI:`CBF_CFG_LAST_LO];
  wire busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire busWr  = busReq && wb_we_i;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [31:0] laneMerge;
    input [31:0] oldV;
    input [31:0] newV;
    input [3:0]  sel;
    integer b;
    begin
      laneMerge = oldV;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          laneMerge[b*8 +: 8] = newV[b*8 +: 8];
        end
      end
    end
  endfunction
  // Mask bit 1 forces the filter bit to match, 0 makes it don't care.
  function maskMatch;
    input [31:0] filt;
    input [31:0] inc;
    input [31:0] mask;
    begin
      maskMatch = ~|((filt ^ inc) & mask);
    end
  endfunction
  // Incoming ID placed as a buffer word: MSB-0 bits 3-31 equal LSB-0 bits 28:0.
  wire [31:0] rxAsBuf = {3'b000, rxId};
  // Format A sits one position to the left: LSB-0 bits 29:1.
  wire [31:0] rxAsFifoA = {2'b00, rxId, 1'b0};
  // Formats B and C keep only upper ID bits in 14- and 8-bit fields.
  wire [31:0] rxAsFifoB = {2'b00, rxId[28:15], 2'b00, rxId[28:15]};
  wire [31:0] rxAsFifoC = {rxId[28:21], rxId[28:21], rxId[28:21], rxId[28:21]};
  wire [1:0]  fifoFmt = fifoReg[31:30];
  wire [31:0] fifoFilt = {2'b00, fifoReg[29:0]};
  wire [31:0] rxFifoWord = (fifoFmt == 2'd0) ? rxAsFifoA :
                           (fifoFmt == 2'd1) ? rxAsFifoB : rxAsFifoC;
  // ----------------------------------------------------------------
  // Acceptance filtering
  // ----------------------------------------------------------------
  reg [31:0] bufMask;
  reg        rxHit;
  reg [1:0]  rxHitIdx;
  reg        fifoHit;
  always @* begin
    rxHit    = 1'b0;
    rxHitIdx = 2'd0;
    bufMask  = gMaskReg;
    for (j = NBUF - 1; j >= 0; j = j - 1) begin
      if (bcc) begin
        bufMask = imrReg[j];
      end else if (j == 14) begin
        bufMask = m14Reg;
      end else if (j == 15) begin
        bufMask = m15Reg;
      end else begin
        bufMask = gMaskReg;
      end
      if (j[1:0] <= lastIdx && codeReg[j] == `CBF_CODE_RXEMPTY &&
          maskMatch(idReg[j], rxAsBuf, bufMask)) begin
        rxHit    = 1'b1;
        rxHitIdx = j[1:0];
      end
    end
    // FIFO uses shared global mask only when enabled and not in compat mode.
    fifoHit = rx_fifo_enable && maskMatch(fifoFilt, rxFifoWord,
                               bcc ? `CBF_MASK_RESET : gMaskReg);
  end
  // ----------------------------------------------------------------
  // Transmit candidate scan
  // ----------------------------------------------------------------
  reg        scanValid;
  reg [1:0]  scanIdx;
  always @* begin
    scanValid = 1'b0;
    scanIdx   = 2'd0;
    for (k = NBUF - 1; k >= 0; k = k - 1) begin
      if (k[1:0] <= lastIdx && (codeReg[k] == `CBF_CODE_TXDATA ||
          abortPend[k])) begin
        scanValid = 1'b1;
        scanIdx   = k[1:0];
      end
    end
  end
  wire lastIsAnswer = codeReg[lastIdx] == `CBF_CODE_RANSWER;
  wire lastMatch = idReg[lastIdx][28:0] == rxIdLatch[28:0];
  wire csWrite = busWr && wb_adr_i >= `CBF_ADDR_MB_BASE &&
                 wb_adr_i < `CBF_ADDR_MB_BASE + 8'h10;
  wire [1:0] wrIdx = wb_adr_i[3:2];
  // ----------------------------------------------------------------
  // Sequential logic
  // ----------------------------------------------------------------
  reg [3:0] evSet;
  always @* begin
    evSet = 4'h0;
    evSet[`CBF_ST_DONE]    = txWon && txReq;
    evSet[`CBF_ST_RXHIT]   = rxIdValid && rxHit;
    evSet[`CBF_ST_FIFOHIT] = rxIdValid && fifoHit;
    evSet[`CBF_ST_STALL]   = scanPend && intermission && lastIsAnswer && !lastMatch;
  end
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cfgReg    <= `CBF_CFG_RESET;
      gMaskReg  <= `CBF_MASK_RESET;
      m14Reg    <= `CBF_MASK_RESET;
      m15Reg    <= `CBF_MASK_RESET;
      statReg   <= 4'h0;
      iMaskReg  <= 4'h0;
      rxResReg  <= 32'h0000_0000;
      fifoReg   <= 32'h0000_0000;
      rxIdLatch <= 32'h0000_0000;
      scanPend  <= 1'b0;
      candValid <= 1'b0;
      candIdx   <= 2'd0;
      stallReg  <= 1'b0;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      txReq     <= 1'b0;
      txIndex   <= 2'd0;
      irq       <= 1'b0;
      for (i = 0; i < NBUF; i = i + 1) begin
        codeReg[i]   <= `CBF_CODE_INACT;
        idReg[i]     <= 32'h0000_0000;
        imrReg[i]    <= `CBF_MASK_RESET;
        abortPend[i] <= 1'b0;
      end
    end else begin
      wb_ack_o <= busReq;
      // Receive result and remote-request scan
      if (rxIdValid) begin
        rxIdLatch <= {3'b000, rxId};
        rxResReg  <= {fifoHit, rxHit, 28'h000_0000, rxHitIdx};
        if (rxRemote) begin
          scanPend <= 1'b1;
        end
      end
      if (scanPend && intermission) begin
        scanPend  <= 1'b0;
        candValid <= scanValid && !evSet[`CBF_ST_STALL];
        candIdx   <= scanIdx;
        stallReg  <= evSet[`CBF_ST_STALL];
      end else if (stallReg && (csWrite || busFrameStart)) begin
        stallReg  <= 1'b0;
        candValid <= scanValid;
        candIdx   <= scanIdx;
      end else if (!stallReg && !scanPend) begin
        candValid <= scanValid;
        candIdx   <= scanIdx;
      end
      // Completed transmission releases abort lock
      if (txWon && txReq) begin
        abortPend[txIndex] <= 1'b0;
        codeReg[txIndex]   <= abortPend[txIndex] ? `CBF_CODE_ABORT : `CBF_CODE_INACT;
      end
      // Register writes
      if (busWr) begin
        case (wb_adr_i)
          `CBF_ADDR_CFG:   cfgReg   <= laneMerge(cfgReg, wb_dat_i, wb_sel_i);
          `CBF_ADDR_GMASK: gMaskReg <= laneMerge(gMaskReg, wb_dat_i, wb_sel_i);
          `CBF_ADDR_M14:   m14Reg   <= laneMerge(m14Reg, wb_dat_i, wb_sel_i);
          `CBF_ADDR_M15:   m15Reg   <= laneMerge(m15Reg, wb_dat_i, wb_sel_i);
          `CBF_ADDR_IMASK: iMaskReg <= wb_sel_i[0] ? wb_dat_i[3:0] : iMaskReg;
          `CBF_ADDR_FIFO:  fifoReg  <= laneMerge(fifoReg, wb_dat_i, wb_sel_i);
          default: begin
            if (csWrite && wb_sel_i[0] && !abortPend[wrIdx]) begin
              if (wb_dat_i[3:0] == `CBF_CODE_ABORT &&
                  codeReg[wrIdx] == `CBF_CODE_TXDATA) begin
                abortPend[wrIdx] <= 1'b1;
              end else begin
                // Deactivation clears state; an in-flight send still sets the done status bit.
                codeReg[wrIdx] <= wb_dat_i[3:0];
              end
            end
            if (wb_adr_i[7:4] >= 4'h8 && wb_adr_i[7:4] < 4'hC && wb_adr_i[3:2] < NBUF) begin
              idReg[wb_adr_i[3:2]] <= laneMerge(idReg[wb_adr_i[3:2]], wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i[7:4] >= 4'hC && wb_adr_i[3:2] < NBUF) begin
              imrReg[wb_adr_i[3:2]] <= laneMerge(imrReg[wb_adr_i[3:2]], wb_dat_i, wb_sel_i);
            end
          end
        endcase
      end
      // Status: read clears, a simultaneous event wins
      if (busReq && !wb_we_i && wb_adr_i == `CBF_ADDR_STAT) begin
        statReg <= evSet;
      end else begin
        statReg <= statReg | evSet;
      end
      irq     <= |((statReg | evSet) & iMaskReg);
      txReq   <= candValid && !stallReg;
      txIndex <= candIdx;
      // Read data
      case (wb_adr_i)
        `CBF_ADDR_CFG:   wb_dat_o <= cfgReg;
        `CBF_ADDR_GMASK: wb_dat_o <= gMaskReg;
        `CBF_ADDR_M14:   wb_dat_o <= m14Reg;
        `CBF_ADDR_M15:   wb_dat_o <= m15Reg;
        `CBF_ADDR_STAT:  wb_dat_o <= {28'h000_0000, statReg};
        `CBF_ADDR_IMASK: wb_dat_o <= {28'h000_0000, iMaskReg};
        `CBF_ADDR_RXID:  wb_dat_o <= rxIdLatch;
        `CBF_ADDR_RXRES: wb_dat_o <= rxResReg;
        `CBF_ADDR_FIFO:  wb_dat_o <= fifoReg;
        `CBF_ADDR_TXSEL: wb_dat_o <= {stallReg, candValid, 28'h000_0000, candIdx};
        default: begin
          wb_dat_o <= 32'h0000_0000;
          if (wb_adr_i[7:4] == 4'h4 && wb_adr_i[3:2] < NBUF) begin
            wb_dat_o <= {27'h000_0000, abortPend[wb_adr_i[3:2]], codeReg[wb_adr_i[3:2]]};
          end
          if (wb_adr_i[7:4] == 4'h8 && wb_adr_i[3:2] < NBUF) begin
            wb_dat_o <= idReg[wb_adr_i[3:2]];
          end
          if (wb_adr_i[7:4] == 4'hC && wb_adr_i[3:2] < NBUF) begin
            wb_dat_o <= imrReg[wb_adr_i[3:2]];
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [rtl/cbf_map.vh]
// Function
// - After abort request, writes to that buffer's state field are ignored until sent.
// - Buffer with pending abort stays active until it wins arbitration and sends.
// - Software deactivates instead; a deactivated buffer may still go out and set the done status bit.
// - State code a marks a remote answer buffer; last index bounds active buffers.
// - After a remote request is received, scan transmit buffers at intermission end and pick best candidate.
// - Last buffer remote answer with ID mismatch cancels candidate; nothing sent next.
// - Stall ends on any control/status rewrite or foreign frame start after intermission.
// - Global mask masks receive buffers, and FIFO entries when FIFO enable set.
// - Buffer ID at bits 3-31; format-A FIFO filter at bits 2-30.
// - Mask bits apply to filter bit positions, not incoming identifier bits.
// - Buffer-14 and buffer-15 masks share global mask layout and alignment.
// - Format-B and format-C filters align differently with a shared mask.
// - FIFO enable clear disables FIFO; shared masks take no part in it.
// - Compatibility bit set selects per-buffer masks, shared masks unused.
// - Shared masks reset to all ones and then alter no filtering.
`ifndef CBF_MAP_VH
`define CBF_MAP_VH
`define CBF_ADDR_CFG      8'h00
`define CBF_ADDR_GMASK    8'h04
`define CBF_ADDR_M14      8'h08
`define CBF_ADDR_M15      8'h0C
`define CBF_ADDR_STAT     8'h10
`define CBF_ADDR_IMASK    8'h14
`define CBF_ADDR_RXID     8'h18
`define CBF_ADDR_RXRES    8'h1C
`define CBF_ADDR_FIFO     8'h20
`define CBF_ADDR_TXSEL    8'h24
`define CBF_ADDR_MB_BASE  8'h40
`define CBF_ADDR_MBID_BASE 8'h80
`define CBF_ADDR_IMR_BASE 8'hC0
`define CBF_CFG_FEN       2
`define CBF_CFG_BCC       15
`define CBF_CFG_LAST_LO   0
`define CBF_CFG_LAST_HI   1
`define CBF_CFG_RESET     32'h0000_0003
`define CBF_MASK_RESET    32'hFFFF_FFFF
`define CBF_CODE_INACT    4'h8
`define CBF_CODE_ABORT    4'h9
`define CBF_CODE_TXDATA   4'hC
`define CBF_CODE_RANSWER  4'hA
`define CBF_CODE_RXEMPTY  4'h4
`define CBF_ST_DONE       0
`define CBF_ST_RXHIT      1
`define CBF_ST_FIFOHIT    2
`define CBF_ST_STALL      3
`endif

// [test/cbf_core_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module cbf_chk (
  input wire logic        ref_clk,       // Clock
  input wire logic        sys_rst,       // Reset
  input wire logic        wb_cyc_i,      // Cycle
  input wire logic        wb_stb_i,      // Strobe
  input wire logic        wb_we_i,       // Write
  input wire logic [7:0]  wb_adr_i,      // Address
  input wire logic [31:0] wb_dat_o,      // Read data
  input wire logic        wb_ack_o,      // Ack
  input wire logic        rxIdValid,     // Id strobe
  input wire logic        intermission,  // Gap end
  input wire logic        busFrameStart, // Frame start
  input wire logic        txWon,         // Sent
  input wire logic        txReq,         // Candidate
  input wire logic [1:0]  txIndex,       // Index
  input wire logic        irq            // Interrupt
);
  logic       busy;
  logic [3:0] quietCnt;
  // ----------------------------------------
  // Cycles since the last outside activity
  // ----------------------------------------
  assign busy = wb_cyc_i || rxIdValid || intermission || busFrameStart || txWon;
  always_ff @(posedge ref_clk)
    if (sys_rst || busy)
      quietCnt <= 4'h0;
    else if (quietCnt != 4'hF)
      quietCnt <= quietCnt + 4'h1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !wb_ack_o && !txReq && !irq)
    else $error("outputs active after reset edge");
  unmap_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i inside {[8'h28:8'h3C]}
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  irq_change_a: assert property (!$stable(irq) |-> quietCnt <= 4'h4)
    else $error("irq moved without cause");
  txreq_rise_a: assert property ($rose(txReq) |-> quietCnt <= 4'h6)
    else $error("candidate appeared without cause");
  cand_hold_a: assert property (txReq && !busy && quietCnt > 4'h6
    |=> $stable(txIndex) && txReq) else $error("candidate moved while idle");
  cover property (txWon && txReq);
  cover property ($rose(irq));
  cover property ($fell(txReq) && !txWon);
endmodule
bind cbf_core cbf_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rxIdValid(rxIdValid), .intermission(intermission),
  .busFrameStart(busFrameStart), .txWon(txWon), .txReq(txReq), .txIndex(txIndex), .irq(irq));
`default_nettype wire

// [test/cbf_node.sv]
`timescale 1ns/1ns
`default_nettype none
module cbf_node (
  input  wire logic        ref_clk,       // Clock
  input  wire logic        txReq,         // Candidate present
  output var  logic        rxIdValid,     // Id strobe
  output var  logic [28:0] rxId,          // Identifier
  output var  logic        rxRemote,      // Remote request
  output var  logic        intermission,  // Gap end
  output var  logic        busFrameStart, // Frame start
  output var  logic        txWon          // Sent
);
  initial begin
    rxIdValid = 1'b0;
    rxId = 29'h0;
    rxRemote = 1'b0;
    intermission = 1'b0;
    busFrameStart = 1'b0;
    txWon = 1'b0;
  end
  task automatic frame(input logic [28:0] id, input logic rem, input int gap);
    @(posedge ref_clk) busFrameStart <= 1'b1;
    @(posedge ref_clk) busFrameStart <= 1'b0;
    repeat (gap) @(posedge ref_clk);
    rxIdValid <= 1'b1;
    rxId <= id;
    rxRemote <= rem;
    @(posedge ref_clk) rxIdValid <= 1'b0;
    // Released lines flip so a stale id can never pass
    rxId <= ~id;
    rxRemote <= ~rem;
    repeat (gap) @(posedge ref_clk);
    intermission <= 1'b1;
    @(posedge ref_clk) intermission <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic win(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge ref_clk);
      ok = txReq;
    end
    if (ok) begin
      txWon <= 1'b1;
      @(posedge ref_clk) txWon <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct {logic [31:0] cfg, gm, imr, st; logic [3:0] cs; logic [28:0] id;} cbf_row_t;
  localparam logic [28:0] X = 29'h0123_4567;
  localparam logic [31:0] F = 32'hFFFF_FFFF;
  localparam logic [31:0] M = 32'hFFFF_FFEF;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, v;
  logic        ack, rxIdValid, rxRemote, intermission, busFrameStart, txWon, txReq, irq;
  logic [28:0] rxId;
  logic [1:0]  txIndex;
  int          errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  bit          ok;
  cbf_row_t    rows[10];
  cbf_core u_cbf_core (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rxIdValid(rxIdValid), .rxId(rxId), .rxRemote(rxRemote),
    .intermission(intermission), .busFrameStart(busFrameStart), .txWon(txWon),
    .txReq(txReq), .txIndex(txIndex), .irq(irq));
  cbf_node u_cbf_node (.ref_clk(ref_clk), .txReq(txReq), .rxIdValid(rxIdValid), .rxId(rxId),
    .rxRemote(rxRemote), .intermission(intermission), .busFrameStart(busFrameStart),
    .txWon(txWon));
  always #5 ref_clk = ~ref_clk;
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Wait for ack; only the bench timeout ends a wait that never sees it
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    v = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("ack", 32'h1, {31'h0, ack});
  endtask
  task automatic do_reset;
    @(posedge ref_clk) sys_rst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask
  initial begin
    rows = '{'{32'h3, F, F, 32'h2, 4'h4, X}, '{32'h3, F, F, 32'h0, 4'h4, X ^ 29'h10},
      '{32'h3, M, F, 32'h2, 4'h4, X ^ 29'h10}, '{32'h3, M, F, 32'h0, 4'h4, X ^ 29'h8},
      '{32'h7, M, F, 32'h4, 4'h8, X ^ 29'h8}, '{32'h7, M, F, 32'h0, 4'h8, X ^ 29'h10},
      '{32'h7, F, F, 32'h4, 4'h8, X}, '{32'h3, M, F, 32'h0, 4'h8, X},
      '{32'h8003, M, F, 32'h0, 4'h4, X ^ 29'h10}, '{32'h8003, F, M, 32'h2, 4'h4, X ^ 29'h10}};
    do_reset();
    bus(1'b1, 8'h80, {3'h0, X});
    bus(1'b1, 8'h20, {2'h0, X, 1'b0});
    bus(1'b1, 8'h14, 32'h2);
    foreach (rows[i]) begin
      bus(1'b1, 8'h00, rows[i].cfg);
      bus(1'b1, 8'h04, rows[i].gm);
      bus(1'b1, 8'hC0, rows[i].imr);
      bus(1'b1, 8'h40, {28'h0, rows[i].cs});
      bus(1'b0, 8'h10, 32'h0);
      u_cbf_node.frame(rows[i].id, 1'b0, i % 3);
      chk("irq", {31'h0, rows[i].st[1]}, {31'h0, irq});
      bus(1'b0, 8'h10, 32'h0);
      chk("rxstat", rows[i].st, v & 32'h6);
      repeat (3) @(posedge ref_clk);
      chk("irqclr", 32'h0, {31'h0, irq});
    end
    bus(1'b1, 8'h48, 32'h8);
    bus(1'b1, 8'h4C, 32'h8);
    bus(1'b1, 8'h44, 32'hC);
    bus(1'b1, 8'h44, 32'h9);
    bus(1'b1, 8'h44, 32'h8);
    bus(1'b0, 8'h44, 32'h0);
    chk("abortpend", 32'h10, v & 32'h10);
    chk("stillact", 32'h5, {29'h0, txReq, txIndex});
    u_cbf_node.win(ok);
    bus(1'b0, 8'h10, 32'h0);
    chk("done", 32'h1, v & 32'h1);
    bus(1'b1, 8'h44, 32'hC);
    bus(1'b0, 8'h44, 32'h0);
    chk("csfree", 32'hC, v & 32'h1F);
    bus(1'b1, 8'h8C, 32'h155);
    // Last buffer made a remote answer on purpose to provoke the stall
    bus(1'b1, 8'h4C, 32'hA);
    for (int k = 0; k < 3; k++) begin
      u_cbf_node.frame(k == 2 ? 29'h155 : 29'h154, 1'b1, 1);
      bus(1'b0, 8'h10, 32'h0);
      chk("stall", k == 2 ? 32'h0 : 32'h8, v & 32'h8);
      if (k < 2)
        chk("txcancel", 32'h0, {31'h0, txReq});
      if (k == 0)
        u_cbf_node.frame(29'h0AA, 1'b0, 1);
      if (k == 1)
        bus(1'b1, 8'h48, 32'h8);
      repeat (3) @(posedge ref_clk);
      if (k < 2)
        chk("txback", 32'h5, {29'h0, txReq, txIndex});
    end
    bus(1'b1, 8'h28, F);
    bus(1'b0, 8'h28, 32'h0);
    chk("unmapped", 32'h0, v);
    bus(1'b1, 8'h04, 32'h0);
    do_reset();
    for (int a = 0; a < 4; a++) begin
      bus(1'b0, 8'(4 * a), 32'h0);
      chk("resetval", a == 0 ? 32'h3 : F, v);
    end
    end_sim();
  end
endmodule
`default_nettype wire
